// ---- logic/ldprb_mem.sv ----
/*
  Storage array: rows of lanes, two access ports, registered read data.
  Assumes the port logic issues at most one access per port per cycle.
*/
`timescale 1ns/1ps
module ldprb_mem (
  input wire logic clk, // System clock
  ldprb_mem_if.mem m // Array access
);
  // No reset and no preload: contents stay unknown until written
  logic [ldprb_pkg::ROW_BITS-1:0] arr [ldprb_pkg::DEPTH];
  logic [ldprb_pkg::ROW_BITS-1:0] rd_a_r;
  logic [ldprb_pkg::ROW_BITS-1:0] rd_b_r;

  // ----------------------------------------
  // Lane-masked writes, read-before-write
  // ----------------------------------------
  // Same-row collision resolved in code order; port B lands last and wins shared lanes
  always_ff @(posedge clk) begin
    if (m.a_en) begin
      rd_a_r <= arr[m.a_row];
      for (int k = 0; k < ldprb_pkg::LANES; k++) begin
        if (m.a_we && m.a_mask[k]) begin
          arr[m.a_row][k*ldprb_pkg::LANE_W +: ldprb_pkg::LANE_W] <=
            m.a_wd[k*ldprb_pkg::LANE_W +: ldprb_pkg::LANE_W];
        end
      end
    end
    if (m.b_en) begin
      rd_b_r <= arr[m.b_row];
      for (int k = 0; k < ldprb_pkg::LANES; k++) begin
        if (m.b_we && m.b_mask[k]) begin
          arr[m.b_row][k*ldprb_pkg::LANE_W +: ldprb_pkg::LANE_W] <=
            m.b_wd[k*ldprb_pkg::LANE_W +: ldprb_pkg::LANE_W];
        end
      end
    end
  end

  assign m.a_rd = rd_a_r;
  assign m.b_rd = rd_b_r;

  a_capacity_total: assert property (@(posedge clk)
    ldprb_pkg::DEPTH * ldprb_pkg::ROW_BITS == ldprb_pkg::CAPACITY)
    else $error("array capacity differs from total bit count");
endmodule // ldprb_mem

// ---- logic/ldprb_mem_if.sv ----
/*
  Array access signals between the port logic and the storage array.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
interface ldprb_mem_if;
  logic a_en;
  logic a_we;
  logic [ldprb_pkg::ROW_W-1:0] a_row;
  logic [ldprb_pkg::ROW_BITS-1:0] a_wd;
  logic [ldprb_pkg::LANES-1:0] a_mask;
  logic [ldprb_pkg::ROW_BITS-1:0] a_rd;
  logic b_en;
  logic b_we;
  logic [ldprb_pkg::ROW_W-1:0] b_row;
  logic [ldprb_pkg::ROW_BITS-1:0] b_wd;
  logic [ldprb_pkg::LANES-1:0] b_mask;
  logic [ldprb_pkg::ROW_BITS-1:0] b_rd;
  modport ctl (output a_en, a_we, a_row, a_wd, a_mask, b_en, b_we, b_row, b_wd, b_mask,
    input a_rd, b_rd);
  modport mem (input a_en, a_we, a_row, a_wd, a_mask, b_en, b_we, b_row, b_wd, b_mask,
    output a_rd, b_rd);
endinterface

// ---- logic/ldprb_pkg.sv ----
/*
  Shared constants and types of the large dual-port RAM block.
  Assumes one system clock; port clocks arrive as clock enables.
*/
package ldprb_pkg;
  localparam int DEPTH = 4096;
  localparam int LANES = 16;
  localparam int LANE_W = 9;
  localparam int CAPACITY = 589824;
  localparam int PORT_W = 72;
  localparam int MASK_W = 8;
  localparam int ADDR_W = 16;
  localparam int ROW_W = 12;
  localparam int ROW_BITS = LANES * LANE_W;
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] CFG_OFF = 8'h00;
  localparam logic [AXI_AW-1:0] STAT_OFF = 8'h04;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0000_1FFF;
  localparam int F_MODE = 0;
  localparam int F_WA = 2;
  localparam int F_WB = 5;
  localparam int F_NOPAR = 8;
  localparam int F_BYP_A = 9;
  localparam int F_BYP_B = 10;
  localparam int F_OCK_A = 11;
  localparam int F_OCK_B = 12;
  localparam logic [2:0] W144 = 3'h4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {M_TDP, M_SDP, M_SP, M_FIFO} ldprb_mode_t;
  typedef struct packed {
    logic acc;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] din;
    logic [MASK_W-1:0] be;
  } ldprb_in_t;
  typedef struct packed {
    logic aw_h;
    logic w_h;
    logic bv;
    logic rv;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ldprb_axi_t;
endpackage

// ---- logic/ldprb_top.sv ----
/*
  Large dual-port RAM block: two ports, shape and mode set by software.
  Assumes AXI4-Lite master; port clocks given as enables CE_A and CE_B.
*/
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ldprb_top (
  input wire logic CLOCK, // System clock
  input wire logic RST, // Async reset, high
  input wire logic AWVALID, // Write address valid
  output logic AWREADY, // Write address ready
  input wire logic [ldprb_pkg::AXI_AW-1:0] AWADDR, // Write address
  input wire logic WVALID, // Write data valid
  output logic WREADY, // Write data ready
  input wire logic [31:0] WDATA, // Write data
  input wire logic [3:0] WSTRB, // Write strobes
  output logic BVALID, // Write response valid
  input wire logic BREADY, // Write response ready
  output logic [1:0] BRESP, // Write response
  input wire logic ARVALID, // Read address valid
  output logic ARREADY, // Read address ready
  input wire logic [ldprb_pkg::AXI_AW-1:0] ARADDR, // Read address
  output logic RVALID, // Read data valid
  input wire logic RREADY, // Read data ready
  output logic [31:0] RDATA, // Read data
  output logic [1:0] RRESP, // Read response
  input wire logic CE_A, // Port A clock enable
  input wire logic CE_B, // Port B clock enable
  input wire logic CLR_A, // Port A clear
  input wire logic CLR_B, // Port B clear
  input wire logic WREN_A, // Port A write select
  input wire logic WREN_B, // Port B write select
  input wire logic [ldprb_pkg::ADDR_W-1:0] ADDR_A, // Port A address
  input wire logic [ldprb_pkg::ADDR_W-1:0] ADDR_B, // Port B address
  input wire logic [ldprb_pkg::PORT_W-1:0] DIN_A, // Port A write data
  input wire logic [ldprb_pkg::PORT_W-1:0] DIN_B, // Port B write data
  input wire logic [ldprb_pkg::MASK_W-1:0] BE_A, // Port A lane mask
  input wire logic [ldprb_pkg::MASK_W-1:0] BE_B, // Port B lane mask
  output logic [ldprb_pkg::PORT_W-1:0] DOUT_A, // Port A read data
  output logic [ldprb_pkg::PORT_W-1:0] DOUT_B // Port B read data
);
  ldprb_pkg::ldprb_axi_t ax_r, ax_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  ldprb_pkg::ldprb_in_t in_a_r, in_a_nxt, in_b_r, in_b_nxt;
  logic [3:0] base_a_r, base_a_nxt, base_b_r, base_b_nxt;
  logic [ldprb_pkg::PORT_W-1:0] out_a_r, out_a_nxt, out_b_r, out_b_nxt;
  ldprb_pkg::ldprb_mode_t mode;
  logic [2:0] ca, cb;
  logic np, byp_a, byp_b, cfg_ok, sdp, a_rd_ok, b_wr_ok, b_rd_ok, b_dce, oen_a, oen_b;
  logic [15:0] lin_a, lin_b, be_a, be_b;
  logic [ldprb_pkg::ROW_BITS-1:0] src_a, a144, b144;
  logic [ldprb_pkg::PORT_W-1:0] view_a, view_b;
  ldprb_mem_if mi ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Lane index of an address; high bits beyond the depth drop
  function automatic logic [15:0] lin_f(input logic [15:0] addr, input logic [2:0] c);
    return 16'({4'h0, addr} << c);
  endfunction

  // Lanes a port may write; the 9-bit shape has no mask
  function automatic logic [15:0] lmask_f(input logic [15:0] be, input logic [2:0] c);
    logic [16:0] keep;
    keep = (17'h00001 << (5'h01 << c)) - 17'h00001;
    return (c == 3'h0) ? 16'h0001 : (be & keep[15:0]);
  endfunction

  // Byte shapes spread into 9-bit lanes, ninth bit zero
  function automatic logic [143:0] exp_f(input logic [143:0] src, input logic nopar);
    logic [143:0] res;
    res = src;
    if (nopar) begin
      for (int k = 0; k < ldprb_pkg::LANES; k++) begin
        res[9*k +: 9] = {1'b0, src[8*k +: 8]};
      end
    end
    return res;
  endfunction

  // Lanes of a row brought down to a port, packed by byte if needed
  function automatic logic [143:0] align_f(input logic [143:0] rd, input logic [3:0] base,
      input logic [2:0] c, input logic nopar);
    logic [143:0] sh;
    logic [143:0] res;
    sh = rd >> (9 * base);
    res = '0;
    for (int k = 0; k < ldprb_pkg::LANES; k++) begin
      if (k < (1 << c)) begin
        if (nopar) begin
          res[8*k +: 8] = sh[9*k +: 8];
        end else begin
          res[9*k +: 9] = sh[9*k +: 9];
        end
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  always_comb begin
    mode = ldprb_pkg::ldprb_mode_t'(cfg_r[ldprb_pkg::F_MODE +: 2]);
    ca = cfg_r[ldprb_pkg::F_WA +: 3];
    cb = cfg_r[ldprb_pkg::F_WB +: 3];
    np = cfg_r[ldprb_pkg::F_NOPAR];
    byp_a = cfg_r[ldprb_pkg::F_BYP_A];
    byp_b = cfg_r[ldprb_pkg::F_BYP_B];
    sdp = (mode == ldprb_pkg::M_SDP) || (mode == ldprb_pkg::M_FIFO);
    cfg_ok = (ca <= ldprb_pkg::W144) && (cb <= ldprb_pkg::W144);
    if (mode == ldprb_pkg::M_TDP && (ca == ldprb_pkg::W144 || cb == ldprb_pkg::W144)) begin
      cfg_ok = 1'b0;
    end else if (sdp && ((ca == ldprb_pkg::W144) != (cb == ldprb_pkg::W144))) begin
      cfg_ok = 1'b0;
    end
    a_rd_ok = (mode == ldprb_pkg::M_TDP) || (mode == ldprb_pkg::M_SP);
    b_wr_ok = (mode == ldprb_pkg::M_TDP);
    b_rd_ok = (mode != ldprb_pkg::M_SP);
    // Write side shares the write clock in simple dual mode
    b_dce = sdp ? CE_A : CE_B;
    // Output registers may follow the other port's clock
    oen_a = cfg_r[ldprb_pkg::F_OCK_A] ? CE_B : CE_A;
    oen_b = cfg_r[ldprb_pkg::F_OCK_B] ? CE_A : CE_B;
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  always_comb begin
    ax_nxt = ax_r;
    cfg_nxt = cfg_r;
    if (AWVALID && AWREADY) begin
      ax_nxt.aw_h = 1'b1;
      ax_nxt.awaddr = AWADDR;
    end
    if (WVALID && WREADY) begin
      ax_nxt.w_h = 1'b1;
      ax_nxt.wdata = WDATA;
      ax_nxt.wstrb = WSTRB;
    end
    if (ax_r.aw_h && ax_r.w_h && !ax_r.bv) begin
      ax_nxt.aw_h = 1'b0;
      ax_nxt.w_h = 1'b0;
      ax_nxt.bv = 1'b1;
      ax_nxt.bresp = ldprb_pkg::RESP_OK;
      if (ax_r.awaddr == ldprb_pkg::CFG_OFF) begin
        for (int b = 0; b < 4; b++) begin
          if (ax_r.wstrb[b]) begin
            cfg_nxt[8*b +: 8] = ax_r.wdata[8*b +: 8];
          end
        end
        cfg_nxt = cfg_nxt & ldprb_pkg::CFG_MASK;
      end else if (ax_r.awaddr != ldprb_pkg::STAT_OFF) begin
        ax_nxt.bresp = ldprb_pkg::RESP_SLVERR;
      end
    end
    if (ax_r.bv && BREADY) begin
      ax_nxt.bv = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      ax_nxt.rv = 1'b1;
      ax_nxt.rresp = ldprb_pkg::RESP_OK;
      if (ARADDR == ldprb_pkg::CFG_OFF) begin
        ax_nxt.rdata = cfg_r;
      end else if (ARADDR == ldprb_pkg::STAT_OFF) begin
        ax_nxt.rdata = {31'h0000_0000, !cfg_ok};
      end else begin
        ax_nxt.rdata = 32'h0000_0000;
        ax_nxt.rresp = ldprb_pkg::RESP_SLVERR;
      end
    end else if (ax_r.rv && RREADY) begin
      ax_nxt.rv = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ax_r <= '0;
      cfg_r <= ldprb_pkg::CFG_RST;
    end else begin
      ax_r <= ax_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign AWREADY = !ax_r.aw_h && !ax_r.bv;
  assign WREADY = !ax_r.w_h && !ax_r.bv;
  assign BVALID = ax_r.bv;
  assign BRESP = ax_r.bresp;
  assign ARREADY = !ax_r.rv;
  assign RVALID = ax_r.rv;
  assign RDATA = ax_r.rdata;
  assign RRESP = ax_r.rresp;

  // ----------------------------------------
  // Port input registers
  // ----------------------------------------
  // Fabric drives enables, clears and selects per port
  always_comb begin
    in_a_nxt = in_a_r;
    in_a_nxt.acc = 1'b0;
    if (CLR_A) begin
      in_a_nxt = '0;
    end else if (CE_A) begin
      in_a_nxt = '{acc: cfg_ok, we: WREN_A, addr: ADDR_A, din: DIN_A, be: BE_A};
    end
    in_b_nxt = in_b_r;
    in_b_nxt.acc = 1'b0;
    if (CLR_B) begin
      in_b_nxt = '0;
    end else begin
      if (CE_B) begin
        in_b_nxt.acc = cfg_ok;
        in_b_nxt.we = WREN_B;
        in_b_nxt.addr = ADDR_B;
      end
      if (b_dce) begin
        in_b_nxt.din = DIN_B;
        in_b_nxt.be = BE_B;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      in_a_r <= '0;
      in_b_r <= '0;
    end else begin
      in_a_r <= in_a_nxt;
      in_b_r <= in_b_nxt;
    end
  end

  // ----------------------------------------
  // Array access
  // ----------------------------------------
  always_comb begin
    lin_a = lin_f(in_a_r.addr, ca);
    lin_b = lin_f(in_b_r.addr, cb);
    if (ca == ldprb_pkg::W144) begin
      be_a = {in_b_r.be, in_a_r.be};
      src_a = np ? {16'h0000, in_b_r.din[63:0], in_a_r.din[63:0]} : {in_b_r.din, in_a_r.din};
    end else begin
      be_a = {8'h00, in_a_r.be};
      src_a = {72'h0, in_a_r.din};
    end
    be_b = {8'h00, in_b_r.be};
    // One select chooses write or read; there is no read enable
    mi.a_en = in_a_r.acc && (in_a_r.we || a_rd_ok);
    mi.a_we = in_a_r.we;
    mi.a_row = lin_a[15:4];
    mi.a_mask = lmask_f(be_a, ca) << lin_a[3:0];
    mi.a_wd = exp_f(src_a, np) << (9 * lin_a[3:0]);
    mi.b_en = in_b_r.acc && (in_b_r.we ? b_wr_ok : b_rd_ok);
    mi.b_we = in_b_r.we && b_wr_ok;
    mi.b_row = lin_b[15:4];
    mi.b_mask = lmask_f(be_b, cb) << lin_b[3:0];
    mi.b_wd = exp_f({72'h0, in_b_r.din}, np) << (9 * lin_b[3:0]);
  end

  ldprb_mem u_mem (
    .clk(CLOCK),
    .m(mi)
  );

  // ----------------------------------------
  // Read data and output registers
  // ----------------------------------------
  always_comb begin
    a144 = align_f(mi.a_rd, base_a_r, ca, np);
    b144 = align_f(mi.b_rd, base_b_r, cb, np);
    // A 144-bit port B read in simple dual or FIFO mode spreads over both ports' outputs
    if (sdp && cb == ldprb_pkg::W144) begin
      view_a = np ? {8'h00, b144[63:0]} : b144[71:0];
      view_b = np ? {8'h00, b144[127:64]} : b144[143:72];
    end else begin
      view_a = a144[71:0];
      view_b = b144[71:0];
    end
    base_a_nxt = mi.a_en ? lin_a[3:0] : base_a_r;
    base_b_nxt = mi.b_en ? lin_b[3:0] : base_b_r;
    out_a_nxt = CLR_A ? '0 : (oen_a ? view_a : out_a_r);
    out_b_nxt = CLR_B ? '0 : (oen_b ? view_b : out_b_r);
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      base_a_r <= '0;
      base_b_r <= '0;
      out_a_r <= '0;
      out_b_r <= '0;
    end else begin
      base_a_r <= base_a_nxt;
      base_b_r <= base_b_nxt;
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
    end
  end

  assign DOUT_A = byp_a ? view_a : out_a_r;
  assign DOUT_B = byp_b ? view_b : out_b_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb_main @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_wr_a;
    CE_A && !CLR_A && WREN_A && cfg_ok;
  endsequence
  sequence s_rd_a;
    CE_A && !CLR_A && !WREN_A && cfg_ok && a_rd_ok;
  endsequence

  a_write_timing: assert property (s_wr_a |=> mi.a_en && mi.a_we)
    else $error("captured write did not reach array next cycle");
  a_read_select: assert property (s_rd_a |=> mi.a_en && !mi.a_we)
    else $error("low write select did not read");
  a_bypass_path: assert property (s_rd_a ##0 (byp_a && ca == 3'h3 && !np) ##3
    (byp_a && ca == 3'h3 && !np) |-> DOUT_A == 72'(mi.a_rd >> (9 * base_a_r)))
    else $error("bypassed output not showing array data");
  a_out_hold: assert property (!oen_a && !CLR_A |=> $stable(out_a_r))
    else $error("output register moved without its clock");
  a_tdp_reject: assert property (
    mode == ldprb_pkg::M_TDP && ca == ldprb_pkg::W144 |-> !cfg_ok)
    else $error("wide shape accepted in true dual mode");
  a_sdp_pairing: assert property (sdp && (ca == ldprb_pkg::W144) !=
    (cb == ldprb_pkg::W144) |-> !cfg_ok)
    else $error("wide shape paired with narrow one");
  a_tdp_pairs: assert property (
    mode == ldprb_pkg::M_TDP && ca < ldprb_pkg::W144 && cb < ldprb_pkg::W144 |-> cfg_ok)
    else $error("legal true dual pairing refused");
  a_err_blocks: assert property (CE_A && !CLR_A && !cfg_ok |=> !mi.a_en)
    else $error("access issued under refused shape");
  a_lane_window: assert property (mi.a_en && mi.a_we |->
    (mi.a_mask & ~(lmask_f(16'hFFFF, ca) << lin_a[3:0])) == 16'h0000)
    else $error("write touched lanes outside the port word");
  a_full_mask: assert property (mi.a_en && mi.a_we && in_a_r.be == 8'hFF &&
    ca == 3'h3 |-> $countones(mi.a_mask) == 8)
    else $error("all-high mask did not write whole word");
  a_b_no_write: assert property (mode != ldprb_pkg::M_TDP |-> !mi.b_we)
    else $error("port B wrote outside true dual mode");
endmodule // ldprb_top

// ---- verif/ldprb_fabric.sv ----
/*
  Fabric-side model driving the two memory ports of the RAM block.
  Assumes one system clock; port clocks are given as one-cycle enables.
*/
`timescale 1ns/1ps
module ldprb_fabric (
  input wire logic clk, // System clock
  output logic ce_a, // Port A enable
  output logic ce_b, // Port B enable
  output logic clr_a, // Port A clear
  output logic clr_b, // Port B clear
  output logic wren_a, // Port A write select
  output logic wren_b, // Port B write select
  output logic [ldprb_pkg::ADDR_W-1:0] addr_a, // Port A address
  output logic [ldprb_pkg::ADDR_W-1:0] addr_b, // Port B address
  output logic [ldprb_pkg::PORT_W-1:0] din_a, // Port A data
  output logic [ldprb_pkg::PORT_W-1:0] din_b, // Port B data
  output logic [ldprb_pkg::MASK_W-1:0] be_a, // Port A mask
  output logic [ldprb_pkg::MASK_W-1:0] be_b // Port B mask
);
  initial begin
    ce_a = 1'b0;
    ce_b = 1'b0;
    clr_a = 1'b0;
    clr_b = 1'b0;
    wren_a = 1'b0;
    wren_b = 1'b0;
    addr_a = 16'h0000;
    addr_b = 16'h0000;
    din_a = 72'h0;
    din_b = 72'h0;
    be_a = 8'hFF;
    be_b = 8'hFF;
  end

  // ----------------------------------------
  // One enable pulse carrying both ports
  // ----------------------------------------
  task automatic pulse(input logic pa, input logic pb, input logic wa, input logic wb,
      input logic [15:0] aa, input logic [15:0] ab, input logic [71:0] da,
      input logic [71:0] db, input logic [7:0] ma, input logic [7:0] mb);
    @(posedge clk);
    ce_a <= pa;
    ce_b <= pb;
    wren_a <= wa;
    wren_b <= wb;
    addr_a <= aa;
    addr_b <= ab;
    din_a <= da;
    din_b <= db;
    be_a <= ma;
    be_b <= mb;
    @(posedge clk);
    ce_a <= 1'b0;
    ce_b <= 1'b0;
    // Released address and data lines show garbage, never the last value
    addr_a <= ~aa;
    addr_b <= ~ab;
    din_a <= ~da;
    din_b <= ~db;
  endtask

  // One-cycle synchronous clear on either port
  task automatic clear(input logic pa, input logic pb);
    @(posedge clk);
    clr_a <= pa;
    clr_b <= pb;
    @(posedge clk);
    clr_a <= 1'b0;
    clr_b <= 1'b0;
  endtask
endmodule // ldprb_fabric

// ---- verif/ldprb_top_tb.sv ----
/*
  Self-checking bench of the RAM block: register bus and both ports.
  Assumes the fabric model and the design package are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ldprb_top_tb;
  logic CLOCK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic CE_A, CE_B, CLR_A, CLR_B, WREN_A, WREN_B;
  logic [15:0] ADDR_A, ADDR_B;
  logic [71:0] DIN_A, DIN_B, DOUT_A, DOUT_B;
  logic [7:0] BE_A, BE_B;
  int fails, n_compared, cyc;
  logic [71:0] d1, mrg;

  ldprb_top ldprb_top_i (.CLOCK, .RST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
    .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID,
    .RREADY, .RDATA, .RRESP, .CE_A, .CE_B, .CLR_A, .CLR_B, .WREN_A, .WREN_B, .ADDR_A,
    .ADDR_B, .DIN_A, .DIN_B, .BE_A, .BE_B, .DOUT_A, .DOUT_B);
  ldprb_fabric ldprb_fabric_i (.clk(CLOCK), .ce_a(CE_A), .ce_b(CE_B), .clr_a(CLR_A),
    .clr_b(CLR_B), .wren_a(WREN_A), .wren_b(WREN_B), .addr_a(ADDR_A), .addr_b(ADDR_B),
    .din_a(DIN_A), .din_b(DIN_B), .be_a(BE_A), .be_b(BE_B));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // ----------------------------------------
  // Verdict and hang guard
  // ----------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Bus and port helpers
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    logic aw_now;
    logic w_now;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge CLOCK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= 4'hF;
    BREADY <= 1'b1;
    // Ready read settled mid-cycle; the handshake is the next rising edge
    while (!(aw_ok && w_ok)) begin
      @(negedge CLOCK);
      aw_now = !aw_ok && (AWREADY === 1'b1);
      w_now = !w_ok && (WREADY === 1'b1);
      @(posedge CLOCK);
      if (aw_now) begin
        aw_ok = 1'b1;
        AWVALID <= 1'b0;
      end
      if (w_now) begin
        w_ok = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do @(negedge CLOCK); while (BVALID !== 1'b1);
    `CHK(BRESP, ldprb_pkg::RESP_OK)
    @(posedge CLOCK);
    BREADY <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge CLOCK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do @(negedge CLOCK); while (ARREADY !== 1'b1);
    @(posedge CLOCK);
    ARVALID <= 1'b0;
    do @(negedge CLOCK); while (RVALID !== 1'b1);
    `CHK(RDATA, e)
    `CHK(RRESP, r)
    @(posedge CLOCK);
    RREADY <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [71:0] da, input logic [71:0] db,
      input logic [7:0] ma, input logic [7:0] mb);
    ldprb_fabric_i.pulse(1'b1, 1'b0, 1'b1, 1'b0, a, 16'h0000, da, db, ma, mb);
  endtask

  // Read on port B when b is set, else port A; sample one edge after capture
  task automatic rd(input logic b, input logic [15:0] a);
    ldprb_fabric_i.pulse(!b, b, 1'b0, 1'b0, a, a, 72'h0, 72'h0, 8'hFF, 8'hFF);
    @(posedge CLOCK);
    #1;
  endtask

  function automatic logic [71:0] merge9(input logic [71:0] o, input logic [71:0] n,
      input logic [7:0] m);
    logic [71:0] r;
    for (int k = 0; k < 8; k++) begin
      r[9*k +: 9] = m[k] ? n[9*k +: 9] : o[9*k +: 9];
    end
    return r;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fails = 0;
    n_compared = 0;
    cyc = 0;
    RST = 1'b1;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    d1 = 72'h12_3456_789A_BCDE_F012;
    mrg = merge9(d1, ~d1, 8'hA5);
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    axi_rd(8'h00, 32'h0, ldprb_pkg::RESP_OK);
    axi_rd(8'h04, 32'h0, ldprb_pkg::RESP_OK);
    axi_rd(8'h08, 32'h0, ldprb_pkg::RESP_SLVERR);
    // True dual, both x72, both bypassed
    axi_wr(8'h00, 32'h0000_066C);
    axi_rd(8'h00, 32'h0000_066C, ldprb_pkg::RESP_OK);
    // Collisions kept apart: one port active per pulse
    wr(16'h0004, d1, 72'h0, 8'hFF, 8'hFF);
    rd(1'b1, 16'h0004);
    `CHK(DOUT_B, d1)
    wr(16'h0004, ~d1, 72'h0, 8'hA5, 8'hFF);
    rd(1'b0, 16'h0004);
    `CHK(DOUT_A, mrg)
    rd(1'b1, 16'h0004);
    `CHK(DOUT_B, mrg)
    // Port A x9 against port B x72; x9 ignores the mask
    axi_wr(8'h00, 32'h0000_0660);
    wr(16'h0013, 72'h1A5, 72'h0, 8'h00, 8'hFF);
    rd(1'b1, 16'h0002);
    `CHK(DOUT_B[35:27], 9'h1A5)
    // x144 on port A in true dual is refused, and so is its write
    axi_wr(8'h00, 32'h0000_0610);
    axi_rd(8'h04, 32'h1, ldprb_pkg::RESP_OK);
    wr(16'h0002, 72'h0, 72'h0, 8'hFF, 8'hFF);
    // Simple dual x144, joined 16-lane mask
    axi_wr(8'h00, 32'h0000_0691);
    axi_rd(8'h04, 32'h0, ldprb_pkg::RESP_OK);
    wr(16'h0005, d1, ~d1, 8'hFF, 8'hFF);
    wr(16'h0005, 72'h0, 72'h0, 8'h00, 8'h80);
    rd(1'b1, 16'h0005);
    `CHK(DOUT_A, d1)
    `CHK(DOUT_B, {9'h000, ~d1[62:0]})
    // Registered outputs lag one enable behind the array
    axi_wr(8'h00, 32'h0000_006C);
    rd(1'b1, 16'h0004);
    rd(1'b1, 16'h000A);
    `CHK(DOUT_B, mrg)
    rd(1'b1, 16'h000A);
    `CHK(DOUT_B, d1)
    // Port B output register follows port A's enable
    axi_wr(8'h00, 32'h0000_106C);
    rd(1'b1, 16'h0004);
    `CHK(DOUT_B, d1)
    rd(1'b0, 16'h0004);
    `CHK(DOUT_B, mrg)
    ldprb_fabric_i.clear(1'b0, 1'b1);
    #1;
    `CHK(DOUT_B, 72'h0)
    // Single port: port B stays idle, its read flop keeps the old row
    axi_wr(8'h00, 32'h0000_066E);
    rd(1'b0, 16'h0004);
    `CHK(DOUT_A, mrg)
    rd(1'b1, 16'h000A);
    `CHK(DOUT_B, mrg)
    // FIFO storage, x64 byte lanes, low four bytes rewritten
    axi_wr(8'h00, 32'h0000_076F);
    wr(16'h0006, d1, 72'h0, 8'hFF, 8'hFF);
    wr(16'h0006, ~d1, 72'h0, 8'h0F, 8'hFF);
    rd(1'b1, 16'h0006);
    `CHK(DOUT_B, {8'h00, d1[63:32], ~d1[31:0]})
    give_verdict();
  end
endmodule // ldprb_top_tb
